// >>> design/cgs_gpio_top.sv
/*
 * Camera GPIO block: four lines, each input, output, trigger or strobe,
 * with an APB register file, trigger detection and pin drivers.
 * Assumes pins are asynchronous to pclk; the pad provides the pull-up.
 */
`timescale 1ns/1ps
`include "cgs_gpio_cfg.svh"
module cgs_gpio_top (
    input  wire logic           pclk,
    input  wire logic           presetn,
    input  wire logic           psel,
    input  wire logic           penable,
    input  wire logic           pwrite,
    input  wire logic [7:0]     paddr,
    input  wire logic [31:0]    pwdata,
    output logic [31:0]         prdata,
    output logic                pready,
    output logic                pslverr,
    input  wire cgs_pkg::cgs_lines_type gpio_in,
    output cgs_pkg::cgs_lines_type      gpio_out,
    output cgs_pkg::cgs_lines_type      gpio_oe_n,
    output logic                frame_start,
    output logic                integrating
);
    import cgs_pkg::*;

    cgs_top_type cur_ff;
    cgs_top_type nxt_top;
    logic [1:0]  src;
    logic        rise;
    logic        fall;
    logic        acc;
    logic        wr;

    cgs_link_if lk ();

    cgs_expo_seq u_seq (
        .pclk    (pclk),
        .presetn (presetn),
        .lk      (lk.seq)
    );

    cgs_strobe_gen u_stb (
        .pclk    (pclk),
        .presetn (presetn),
        .lk      (lk.stb)
    );

    // Mode field of one line
    function automatic logic [1:0] line_mode(input logic [7:0] modes, input logic [1:0] idx);
        line_mode = modes[{idx, 1'b0} +: 2];
    endfunction

    // Modes in which a line may serve as trigger source
    function automatic logic takes_trig(input logic [1:0] m);
        takes_trig = (m == `CGS_MODE_IN) || (m == `CGS_MODE_TRIG);
    endfunction

    assign lk.ext_en   = cur_ff.ctrl[`CGS_CTRL_EXT];
    assign lk.trig     = cur_ff.trig;
    assign lk.shutter  = cur_ff.shutter;
    assign lk.period   = cur_ff.period;
    assign lk.delay    = cur_ff.delay;
    assign lk.dur      = cur_ff.dur;
    assign lk.pat_en   = cur_ff.pat_en;
    assign lk.pat_len  = cur_ff.pat_len;
    assign lk.pat_mask = cur_ff.pat_mask;

    always_comb begin
        nxt_top = cur_ff;
        src = cur_ff.ctrl[`CGS_CTRL_SRC_MSB:`CGS_CTRL_SRC_LSB];
        acc = psel && penable;
        wr = acc && pwrite && cur_ff.pready;

        // Three-stage synchroniser; level follows once stages two and three agree
        nxt_top.s1 = gpio_in;
        nxt_top.s2 = cur_ff.s1;
        nxt_top.s3 = cur_ff.s2;
        for (int i = 0; i < 4; i++) begin
            if (cur_ff.s2[i] == cur_ff.s3[i]) begin
                nxt_top.lvl[i] = cur_ff.s3[i];
            end
        end
        nxt_top.lvl_d = cur_ff.lvl;

        // Trigger edge on the selected source line
        rise = cur_ff.lvl[src] && !cur_ff.lvl_d[src];
        fall = !cur_ff.lvl[src] && cur_ff.lvl_d[src];
        nxt_top.trig = cur_ff.ctrl[`CGS_CTRL_EXT]
                       && takes_trig(line_mode(cur_ff.mode, src))
                       && (cur_ff.ctrl[`CGS_CTRL_POL] ? rise : fall);

        // APB: answer one cycle after the access phase begins
        nxt_top.pready = 1'b0;
        nxt_top.pslverr = 1'b0;
        if (acc && !cur_ff.pready) begin
            nxt_top.pready = 1'b1;
            nxt_top.prdata = '0;
            case (paddr)
                `CGS_ADDR_CTRL: begin
                    nxt_top.prdata[3:0] = cur_ff.ctrl;
                end
                `CGS_ADDR_MODE: begin
                    nxt_top.prdata[7:0] = cur_ff.mode;
                end
                `CGS_ADDR_OUT: begin
                    nxt_top.prdata[3:0] = cur_ff.out_val;
                end
                `CGS_ADDR_DELAY: begin
                    nxt_top.prdata[15:0] = cur_ff.delay;
                end
                `CGS_ADDR_DUR: begin
                    nxt_top.prdata[15:0] = cur_ff.dur;
                end
                `CGS_ADDR_SHUTTER: begin
                    nxt_top.prdata[15:0] = cur_ff.shutter;
                end
                `CGS_ADDR_PERIOD: begin
                    nxt_top.prdata[23:0] = cur_ff.period;
                end
                `CGS_ADDR_PATTERN: begin
                    nxt_top.prdata[`CGS_PAT_EN] = cur_ff.pat_en;
                    nxt_top.prdata[`CGS_PAT_LEN_MSB:`CGS_PAT_LEN_LSB] = cur_ff.pat_len;
                    nxt_top.prdata[`CGS_PAT_MASK_MSB:0] = cur_ff.pat_mask;
                end
                `CGS_ADDR_STATUS: begin
                    nxt_top.prdata[3:0] = cur_ff.lvl;
                    nxt_top.prdata[4] = lk.strobe;
                    nxt_top.prdata[5] = lk.integrating;
                end
                default: begin
                    nxt_top.pslverr = 1'b1;
                end
            endcase
        end

        // Writes land at the edge where the master sees pready
        if (wr) begin
            case (paddr)
                `CGS_ADDR_CTRL: begin
                    nxt_top.ctrl = pwdata[3:0];
                end
                `CGS_ADDR_MODE: begin
                    nxt_top.mode = pwdata[7:0];
                end
                `CGS_ADDR_OUT: begin
                    nxt_top.out_val = pwdata[3:0];
                end
                `CGS_ADDR_DELAY: begin
                    nxt_top.delay = pwdata[15:0];
                end
                `CGS_ADDR_DUR: begin
                    nxt_top.dur = pwdata[15:0];
                end
                `CGS_ADDR_SHUTTER: begin
                    nxt_top.shutter = pwdata[15:0];
                end
                `CGS_ADDR_PERIOD: begin
                    nxt_top.period = pwdata[23:0];
                end
                `CGS_ADDR_PATTERN: begin
                    nxt_top.pat_en = pwdata[`CGS_PAT_EN];
                    nxt_top.pat_len = pwdata[`CGS_PAT_LEN_MSB:`CGS_PAT_LEN_LSB];
                    nxt_top.pat_mask = pwdata[`CGS_PAT_MASK_MSB:0];
                end
                default: begin
                    nxt_top.ctrl = cur_ff.ctrl;
                end
            endcase
        end

        // Pin drivers; enable is active low
        for (int i = 0; i < 4; i++) begin
            case (line_mode(cur_ff.mode, i[1:0]))
                `CGS_MODE_OUT: begin
                    nxt_top.pin_out[i] = cur_ff.out_val[i];
                    nxt_top.pin_oe_n[i] = 1'b0;
                end
                `CGS_MODE_STRB: begin
                    nxt_top.pin_out[i] = lk.strobe;
                    nxt_top.pin_oe_n[i] = 1'b0;
                end
                default: begin
                    nxt_top.pin_out[i] = 1'b0;
                    nxt_top.pin_oe_n[i] = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_ff <= '0;
            cur_ff.mode <= `CGS_RST_MODE;
            cur_ff.ctrl <= `CGS_RST_CTRL;
            cur_ff.delay <= `CGS_RST_DELAY;
            cur_ff.dur <= `CGS_RST_DUR;
            cur_ff.shutter <= `CGS_RST_SHUTTER;
            cur_ff.period <= `CGS_RST_PERIOD;
            cur_ff.s1 <= `CGS_RST_PIN;
            cur_ff.s2 <= `CGS_RST_PIN;
            cur_ff.s3 <= `CGS_RST_PIN;
            cur_ff.lvl <= `CGS_RST_PIN;
            cur_ff.lvl_d <= `CGS_RST_PIN;
            cur_ff.pin_oe_n <= `CGS_RST_PIN;
        end else begin
            cur_ff <= nxt_top;
        end
    end

    assign prdata      = cur_ff.prdata;
    assign pready      = cur_ff.pready;
    assign pslverr     = cur_ff.pslverr;
    assign gpio_out    = cur_ff.pin_out;
    assign gpio_oe_n   = cur_ff.pin_oe_n;
    assign frame_start = lk.integ_start;
    assign integrating = lk.integrating;
endmodule

// >>> design/cgs_gpio_cfg.svh
/*
 * Register map, field positions, mode codes and reset values of the camera GPIO block.
 * Assumes an APB slave with an 8-bit byte address and 32-bit data.
 */
`ifndef CGS_GPIO_CFG_SVH
`define CGS_GPIO_CFG_SVH

`define CGS_ADDR_CTRL     8'h00
`define CGS_ADDR_MODE     8'h04
`define CGS_ADDR_OUT      8'h08
`define CGS_ADDR_DELAY    8'h0c
`define CGS_ADDR_DUR      8'h10
`define CGS_ADDR_SHUTTER  8'h14
`define CGS_ADDR_PERIOD   8'h18
`define CGS_ADDR_PATTERN  8'h1c
`define CGS_ADDR_STATUS   8'h20

`define CGS_CTRL_EXT      0
`define CGS_CTRL_POL      1
`define CGS_CTRL_SRC_LSB  2
`define CGS_CTRL_SRC_MSB  3
`define CGS_PAT_MASK_MSB  7
`define CGS_PAT_LEN_LSB   8
`define CGS_PAT_LEN_MSB   10
`define CGS_PAT_EN        31

`define CGS_MODE_IN       2'h0
`define CGS_MODE_OUT      2'h1
`define CGS_MODE_TRIG     2'h2
`define CGS_MODE_STRB     2'h3

`define CGS_RST_CTRL      4'h0
`define CGS_RST_MODE      8'h00
`define CGS_RST_DELAY     16'h0000
`define CGS_RST_DUR       16'h0000
`define CGS_RST_SHUTTER   16'h03e8
`define CGS_RST_PERIOD    24'h0a2c2a
`define CGS_RST_PIN       4'hf

`endif

// >>> design/cgs_pkg.sv
/*
 * Types shared by the camera GPIO top, exposure sequencer and strobe generator.
 * Assumes cgs_gpio_cfg.svh for all numeric constants.
 */
package cgs_pkg;
    typedef logic [3:0] cgs_lines_type;
    typedef enum logic [0:0] {SEQ_IDLE, SEQ_INTEG} cgs_seq_state_type;
    typedef enum logic [1:0] {STB_IDLE, STB_DELAY, STB_PULSE} cgs_stb_state_type;

    typedef struct packed {
        cgs_seq_state_type state;
        logic [23:0]       pcnt;
        logic [15:0]       ecnt;
        logic              start;
    } cgs_seq_type;

    typedef struct packed {
        cgs_stb_state_type state;
        logic [15:0]       cnt;
        logic [2:0]        phase;
        logic              level;
    } cgs_stb_type;

    typedef struct packed {
        logic [7:0]    mode;
        logic [3:0]    out_val;
        logic [3:0]    ctrl;
        logic [15:0]   delay;
        logic [15:0]   dur;
        logic [15:0]   shutter;
        logic [23:0]   period;
        logic          pat_en;
        logic [2:0]    pat_len;
        logic [7:0]    pat_mask;
        cgs_lines_type s1;
        cgs_lines_type s2;
        cgs_lines_type s3;
        cgs_lines_type lvl;
        cgs_lines_type lvl_d;
        logic          trig;
        logic [31:0]   prdata;
        logic          pready;
        logic          pslverr;
        cgs_lines_type pin_out;
        cgs_lines_type pin_oe_n;
    } cgs_top_type;
endpackage

// >>> design/cgs_link_if.sv
/*
 * Interface joining the GPIO top with the exposure sequencer and strobe generator.
 * Assumes all members change on pclk only.
 */
`timescale 1ns/1ps
interface cgs_link_if;
    logic        ext_en;
    logic        trig;
    logic [15:0] shutter;
    logic [23:0] period;
    logic [15:0] delay;
    logic [15:0] dur;
    logic        pat_en;
    logic [2:0]  pat_len;
    logic [7:0]  pat_mask;
    logic        integ_start;
    logic        integrating;
    logic        strobe;

    modport top (output ext_en, trig, shutter, period, delay, dur, pat_en, pat_len,
                 pat_mask, input integ_start, integrating, strobe);
    modport seq (input ext_en, trig, shutter, period, output integ_start, integrating);
    modport stb (input ext_en, trig, shutter, delay, dur, pat_en, pat_len, pat_mask,
                 integ_start, integrating, output strobe);
endinterface

// >>> design/cgs_expo_seq.sv
/*
 * Exposure sequencer: free-running frame starts or trigger-started integration.
 * Assumes trig is a one-cycle pulse already qualified by the top.
 */
`timescale 1ns/1ps
`include "cgs_gpio_cfg.svh"
module cgs_expo_seq (
    input  wire logic pclk,
    input  wire logic presetn,
    cgs_link_if.seq   lk
);
    import cgs_pkg::*;
    cgs_seq_type cur_ff;
    cgs_seq_type nxt_seq;

    always_comb begin
        nxt_seq = cur_ff;
        nxt_seq.start = 1'b0;
        if (lk.ext_en) begin
            nxt_seq.pcnt = '0;
        end else if (cur_ff.pcnt >= lk.period - 24'h1) begin
            nxt_seq.pcnt = '0;
        end else begin
            nxt_seq.pcnt = cur_ff.pcnt + 24'h1;
        end
        case (cur_ff.state)
            SEQ_IDLE: begin
                if ((lk.ext_en && lk.trig) ||
                    (!lk.ext_en && cur_ff.pcnt >= lk.period - 24'h1)) begin
                    nxt_seq.state = SEQ_INTEG;
                    nxt_seq.ecnt = '0;
                    nxt_seq.start = 1'b1;
                end
            end
            SEQ_INTEG: begin
                nxt_seq.ecnt = cur_ff.ecnt + 16'h1;
                if (cur_ff.ecnt + 16'h1 >= lk.shutter) begin
                    nxt_seq.state = SEQ_IDLE;
                end
            end
            default: nxt_seq.state = SEQ_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_ff <= '{state: SEQ_IDLE, pcnt: '0, ecnt: '0, start: 1'b0};
        end else begin
            cur_ff <= nxt_seq;
        end
    end

    assign lk.integ_start = cur_ff.start;
    assign lk.integrating = (cur_ff.state == SEQ_INTEG);
endmodule

// >>> design/cgs_strobe_gen.sv
/*
 * Strobe generator: delay, duration and per-frame pattern of the strobe pulse.
 * Assumes integ_start and trig are one-cycle pulses on pclk.
 */
`timescale 1ns/1ps
`include "cgs_gpio_cfg.svh"
module cgs_strobe_gen (
    input  wire logic pclk,
    input  wire logic presetn,
    cgs_link_if.stb   lk
);
    import cgs_pkg::*;
    cgs_stb_type cur_ff;
    cgs_stb_type nxt_stb;
    logic        ref_evt;
    logic        fire;
    logic [15:0] dur_eff;

    always_comb begin
        nxt_stb = cur_ff;
        // A trigger dropped during exposure makes no frame, so no strobe and no phase step
        ref_evt = lk.ext_en ? (lk.trig && !lk.integrating) : lk.integ_start;
        fire = !lk.pat_en || lk.pat_mask[cur_ff.phase];
        dur_eff = (lk.dur == 16'h0) ? lk.shutter : lk.dur;
        if (!lk.pat_en) begin
            nxt_stb.phase = '0;
        end else if (ref_evt) begin
            nxt_stb.phase = (cur_ff.phase >= lk.pat_len) ? 3'h0 : cur_ff.phase + 3'h1;
        end
        case (cur_ff.state)
            STB_IDLE: begin
                if (ref_evt && fire) begin
                    nxt_stb.cnt = '0;
                    if (lk.delay == 16'h0) begin
                        nxt_stb.state = STB_PULSE;
                        nxt_stb.level = 1'b1;
                    end else begin
                        nxt_stb.state = STB_DELAY;
                    end
                end
            end
            STB_DELAY: begin
                nxt_stb.cnt = cur_ff.cnt + 16'h1;
                if (cur_ff.cnt + 16'h1 >= lk.delay) begin
                    nxt_stb.state = STB_PULSE;
                    nxt_stb.level = 1'b1;
                    nxt_stb.cnt = '0;
                end
            end
            STB_PULSE: begin
                nxt_stb.cnt = cur_ff.cnt + 16'h1;
                if (cur_ff.cnt + 16'h1 >= dur_eff) begin
                    nxt_stb.state = STB_IDLE;
                    nxt_stb.level = 1'b0;
                end
            end
            default: begin
                nxt_stb.state = STB_IDLE;
                nxt_stb.level = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_ff <= '{state: STB_IDLE, cnt: '0, phase: '0, level: 1'b0};
        end else begin
            cur_ff <= nxt_stb;
        end
    end

    assign lk.strobe = cur_ff.level;
endmodule

// >>> dv/cgs_gpio_top_asserts.sv
/*
 * Checker for the camera GPIO top: APB timing, pin drive per mode, exposure.
 * Assumes it sees only the top's ports, attached by the bind below.
 */
`timescale 1ns/1ps
`include "cgs_gpio_cfg.svh"
module cgs_gpio_asserts (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [3:0]  gpio_in,
    input wire logic [3:0]  gpio_out,
    input wire logic [3:0]  gpio_oe_n,
    input wire logic        frame_start,
    input wire logic        integrating
);
    logic        wr_ok;
    logic [7:0]  mode_ff;
    logic [7:0]  mode_d_ff;
    logic [15:0] shut_ff;
    logic [15:0] shl_ff;
    logic [15:0] icnt_ff;
    logic [3:0]  exp_oe_n;

    assign wr_ok = psel && penable && pready && pwrite && !pslverr;
    assign exp_oe_n = ~{mode_d_ff[6], mode_d_ff[4], mode_d_ff[2], mode_d_ff[0]};

    // Shadow registers; the delayed mode copy lets the pin drivers settle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_ff   <= `CGS_RST_MODE;
            mode_d_ff <= `CGS_RST_MODE;
            shut_ff   <= `CGS_RST_SHUTTER;
            shl_ff    <= `CGS_RST_SHUTTER;
            icnt_ff   <= 16'h0000;
        end else begin
            if (wr_ok && paddr == `CGS_ADDR_MODE) mode_ff <= pwdata[7:0];
            if (wr_ok && paddr == `CGS_ADDR_SHUTTER) shut_ff <= pwdata[15:0];
            if (frame_start) shl_ff <= shut_ff;
            mode_d_ff <= mode_ff;
            icnt_ff   <= integrating ? icnt_ff + 16'h0001 : 16'h0000;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_taken;
        psel && penable && !pready;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence

    apb_wait_one_a: assert property (s_taken |=> s_answer)
        else $error("APB answer not after one wait state");
    apb_err_a: assert property (pready && paddr[1:0] == 2'h0 |->
        pslverr == (paddr > `CGS_ADDR_STATUS) && (!pslverr || prdata == 32'h0))
        else $error("APB error response wrong");
    frame_rise_a: assert property (frame_start |-> $rose(integrating))
        else $error("frame start without integration start");
    rise_frame_a: assert property ($rose(integrating) |-> frame_start)
        else $error("integration start without frame start");
    frame_pulse_a: assert property (frame_start |=> !frame_start)
        else $error("frame start longer than one cycle");
    integ_len_a: assert property ($fell(integrating) |->
        icnt_ff == (shl_ff == 16'h0000 ? 16'h0001 : shl_ff))
        else $error("integration length differs from shutter");
    oe_mode_a: assert property (mode_ff == mode_d_ff |-> gpio_oe_n == exp_oe_n)
        else $error("output enable does not follow mode");
    strobe_pair_a: assert property (mode_ff == mode_d_ff && mode_d_ff[7:4] == 4'hf |->
        gpio_out[2] == gpio_out[3])
        else $error("strobe lines not together");
endmodule

bind cgs_gpio_top cgs_gpio_asserts u_asserts (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
    .frame_start(frame_start), .integrating(integrating)
);

// >>> dv/cgs_ext_model.sv
/*
 * External equipment: trigger source on the pins and a light fired by line 3.
 * Assumes released pins rest high through the pull-up.
 */
`timescale 1ns/1ps
module cgs_ext_model (
    input  wire logic       pclk,
    input  wire logic [3:0] gpio_out,
    input  wire logic [3:0] gpio_oe_n,
    input  wire logic [3:0] pull_low,
    output logic [3:0]      gpio_in,
    output int              flashes
);
    logic lit_ff;

    // A driven pin shows the device level, else ground or the pull-up
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            gpio_in[i] = !gpio_oe_n[i] ? gpio_out[i] : !pull_low[i];
        end
    end

    initial flashes = 0;
    always @(posedge pclk) begin
        lit_ff <= gpio_out[3] && !gpio_oe_n[3];
        if (!lit_ff && gpio_out[3] && !gpio_oe_n[3]) flashes <= flashes + 1;
    end
endmodule

// >>> dv/tb.sv
/*
 * Testbench for the camera GPIO block: registers, pin modes, triggers, strobes.
 * Assumes the design, checker and equipment model are compiled before it.
 */
`timescale 1ns/1ps
`include "cgs_gpio_cfg.svh"
module tb;
    import cgs_pkg::*;
    logic          pclk;
    logic          presetn;
    logic          psel;
    logic          penable;
    logic          pwrite;
    logic [7:0]    paddr;
    logic [31:0]   pwdata;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    cgs_lines_type gpio_in;
    cgs_lines_type gpio_out;
    cgs_lines_type gpio_oe_n;
    cgs_lines_type pull_low;
    logic          frame_start;
    logic          integrating;
    int            flashes;
    int            n_fail;
    int            num_checks;
    localparam int D = 4;
    localparam int U = 6;
    localparam int S = 20;

    cgs_gpio_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
        .frame_start(frame_start), .integrating(integrating));
    cgs_ext_model u_ext (.pclk(pclk), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
        .pull_low(pull_low), .gpio_in(gpio_in), .flashes(flashes));

    always #50 pclk = ~pclk;

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int i;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            n_fail++;
            report_and_stop;
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk($sformatf("reg %h", a), x, r);
    endtask

    task automatic wait_fs;
        int i;
        for (i = 0; i < 300; i++) begin
            @(posedge pclk);
            if (frame_start === 1'b1) break;
        end
        if (i == 300) begin
            n_fail++;
            report_and_stop;
        end
    endtask

    // Edge count to strobe rise, strobe width, and further frame starts
    task automatic watch(input int n, output int rise, output int wid, output int nfs);
        rise = 0;
        wid = 0;
        nfs = 0;
        for (int i = 1; i <= n; i++) begin
            @(posedge pclk);
            if (gpio_out[3] === 1'b1 && rise == 0) rise = i;
            wid += (gpio_out[3] === 1'b1);
            nfs += (frame_start === 1'b1);
        end
    endtask

    task automatic t_reset;
        logic [31:0] r;
        logic        e;
        chk("oe_n", 32'hf, {28'h0, gpio_oe_n});
        rdc(`CGS_ADDR_CTRL, 32'h0);
        rdc(`CGS_ADDR_MODE, 32'h0);
        rdc(`CGS_ADDR_SHUTTER, {16'h0, `CGS_RST_SHUTTER});
        rdc(`CGS_ADDR_PERIOD, {8'h0, `CGS_RST_PERIOD});
        rdc(`CGS_ADDR_DUR, 32'h0);
        wr(`CGS_ADDR_STATUS, 32'h0);
        apb(1'b0, `CGS_ADDR_STATUS, 32'h0, r, e);
        chk("pins idle", 32'hf, {28'h0, r[3:0]});
        apb(1'b1, 8'h40, 32'h1, r, e);
        chk("wr err", 32'h1, {31'h0, e});
        apb(1'b0, 8'h40, 32'h0, r, e);
        chk("rd err", 32'h1, {31'h0, e});
        $display("t_reset done");
    endtask

    task automatic t_modes;
        logic [31:0] r;
        logic        e;
        for (int m = 0; m < 4; m++) begin
            wr(`CGS_ADDR_MODE, {24'h0, {4{m[1:0]}}});
            wr(`CGS_ADDR_OUT, 32'ha);
            pull_low <= 4'h5;
            repeat (6) @(posedge pclk);
            chk("oe_n", m[0] ? 32'h0 : 32'hf, {28'h0, gpio_oe_n});
            if (m == 1) chk("out", 32'ha, {28'h0, gpio_out});
            apb(1'b0, `CGS_ADDR_STATUS, 32'h0, r, e);
            if (m == 0) chk("pins", 32'ha, {28'h0, r[3:0]});
            pull_low <= 4'h0;
        end
        $display("t_modes done");
    endtask

    task automatic t_strobe;
        int rise;
        int wid;
        int nfs;
        // Shutter before period: the short period starts a frame at once
        wr(`CGS_ADDR_SHUTTER, S);
        wr(`CGS_ADDR_PERIOD, 32'h64);
        wr(`CGS_ADDR_DELAY, D);
        wr(`CGS_ADDR_MODE, 32'hf0);
        for (int k = 0; k < 2; k++) begin
            wr(`CGS_ADDR_DUR, k ? 0 : U);
            wait_fs;
            wait_fs;
            watch(90, rise, wid, nfs);
            chk("delay", D + 2, rise);
            chk("width", k ? S : U, wid);
            chk("frames", 0, nfs);
        end
        $display("t_strobe done");
    endtask

    task automatic t_pattern;
        logic [31:0] pat[4] = '{32'h0, 32'h80000101, 32'h80000538, 32'h800007a2};
        int          frm[4] = '{4, 4, 6, 8};
        int          want[4] = '{4, 2, 3, 3};
        int          f0;
        wr(`CGS_ADDR_DUR, U);
        for (int k = 0; k < 4; k++) begin
            wr(`CGS_ADDR_PATTERN, pat[k]);
            wait_fs;
            wait_fs;
            f0 = flashes;
            repeat (frm[k] - 1) wait_fs;
            repeat (30) @(posedge pclk);
            chk("flashes", want[k], flashes - f0);
        end
        wr(`CGS_ADDR_PATTERN, 32'h0);
        $display("t_pattern done");
    endtask

    task automatic t_trig;
        int rise;
        int wid;
        int nfs;
        for (int k = 0; k < 2; k++) begin
            // Second pass: rising edge on line 1 in trigger mode
            wr(`CGS_ADDR_MODE, 32'hc0 | (k * 8));
            wr(`CGS_ADDR_CTRL, k ? 32'h7 : 32'h1);
            pull_low <= {2'h0, k[0], 1'b0};
            repeat (2) @(posedge pclk);
            watch(300, rise, wid, nfs);
            chk("no free run", 0, nfs);
            pull_low <= ~pull_low;
            wait_fs;
            fork
                watch(40, rise, wid, nfs);
                begin
                    repeat (3) @(posedge pclk);
                    pull_low <= ~pull_low;
                    repeat (3) @(posedge pclk);
                    pull_low <= ~pull_low;
                end
            join
            chk("trig delay", D + 1, rise);
            chk("trig width", U, wid);
            chk("busy drop", 0, nfs);
            pull_low <= 4'h0;
        end
        wr(`CGS_ADDR_CTRL, 32'h0);
        $display("t_trig done");
    endtask

    initial begin
        pclk       = 1'b0;
        presetn    = 1'b0;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = 8'h00;
        pwdata     = 32'h0;
        pull_low   = 4'h0;
        n_fail     = 0;
        num_checks = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_modes;
        t_strobe;
        t_pattern;
        t_trig;
        report_and_stop;
    end
endmodule
